// *** verilog/fault_irq_ctrl.sv ***
// fault interrupt enables, supply fault flags and interrupt output
`timescale 1ns/1ns

//Function
// - enable reads 0h off, 2h on
// - write 1h disables, 3h enables
// - global enable bits 7-6, resets on
// - bus timeout enable bits 5-4, resets on
// - bad string enable bits 3-2, resets on
// - led fault enable bits 1-0, resets on
// - enable bits 15-8 reserved, reset zero
// - supply status at 0Eh resets zero
// - status bit reads one while latched
// - status plus ack together clears fault
// - crc fault bit 15, ack 14
// - sync loss bit 13, ack 12
// - pump fault bit 11, ack 10
// - pump cap missing bit 9, ack 8
// - input overcurrent bit 7, ack 6
// - core undervoltage bit 5, ack 4
// - input overvoltage bit 3, ack 2
// - input undervoltage bit 1, ack 0
module fault_irq_ctrl
	import fault_irq_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic [ADDR_W-1:0]     reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [DATA_W-1:0]     reg_wdata,
	input  wire logic [NUM_FAULTS-1:0] supply_fault_event,
	input  wire logic [NUM_FAULTS-1:0] supply_fault_en,
	input  wire logic                  i2c_timeout_pending,
	input  wire logic                  bad_string_pending,
	input  wire logic                  led_fault_pending,
	output logic [DATA_W-1:0]          reg_rdata,
	output logic                       reg_rvalid,
	output logic                       fault_irq,
	output logic [NUM_FAULTS-1:0]      fault_flags
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// lower bit qualifies the write, upper bit is the new state
	function automatic logic en_update(input logic cur, input logic [1:0] code);
		logic res;
		res = cur;
		if (code == EN_WR_ON) begin
			res = 1'b1;
		end else if (code == EN_WR_OFF) begin
			res = 1'b0;
		end
		return res;
	endfunction

	function automatic logic [1:0] en_read(input logic en);
		return en ? EN_RD_ON : EN_RD_OFF;
	endfunction

	function automatic logic [1:0] en_field(input logic [DATA_W-1:0] d, input int pos);
		return d[pos +: 2];
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]        rsvd;
		logic              glb_en;
		logic              i2c_en;
		logic              str_en;
		logic              led_en;
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic              irq;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;

	logic                  wr_en_reg;
	logic                  wr_status;
	logic [NUM_FAULTS-1:0] pair_ack;
	logic [NUM_FAULTS-1:0] flags;
	logic [DATA_W-1:0]     en_image;
	logic [DATA_W-1:0]     status_image;
	logic                  pending;

	assign wr_en_reg = reg_wr && (reg_addr == LED_FAULT_IRQ_ENABLES_OFS);
	assign wr_status = reg_wr && (reg_addr == SUPPLY_FAULT_FLAGS_OFS);

	// ****************************************************************
	// supply fault pairs
	// ****************************************************************
	// bit 2*i+1 is the flag, bit 2*i its ack; both must be one
	genvar gi;
	generate
		for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_pair
			assign pair_ack[gi] = wr_status && reg_wdata[2*gi+1] && reg_wdata[2*gi];
			fault_pair_cell u_cell (
				.clock       (clock),
				.rst_n       (rst_n),
				.fault_event (supply_fault_event[gi]),
				.pair_ack    (pair_ack[gi]),
				.flag        (flags[gi])
			);
			assign status_image[2*gi+1] = flags[gi];
			assign status_image[2*gi]   = 1'b0;
		end
	endgenerate

	// index order places crc at 15, sync 13, pump 11, cap 9,
	// overcurrent 7, core uv 5, overvoltage 3, input uv 1

	assign fault_flags = flags;

	// ****************************************************************
	// read images
	// ****************************************************************
	always_comb begin
		en_image = '0;
		en_image[RSVD_POS +: 8]      = st_r.rsvd;
		en_image[GLOBAL_EN_POS +: 2] = en_read(st_r.glb_en);
		en_image[I2C_EN_POS +: 2]    = en_read(st_r.i2c_en);
		en_image[STRING_EN_POS +: 2] = en_read(st_r.str_en);
		en_image[LED_EN_POS +: 2]    = en_read(st_r.led_en);
	end

	// led side events arrive already latched from their own register
	assign pending = (|(flags & supply_fault_en))
		|| (i2c_timeout_pending && st_r.i2c_en)
		|| (bad_string_pending && st_r.str_en)
		|| (led_fault_pending && st_r.led_en);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = reg_rd;
		if (wr_en_reg) begin
			st_nxt.rsvd   = reg_wdata[RSVD_POS +: 8];
			st_nxt.glb_en = en_update(st_r.glb_en, en_field(reg_wdata, GLOBAL_EN_POS));
			st_nxt.i2c_en = en_update(st_r.i2c_en, en_field(reg_wdata, I2C_EN_POS));
			st_nxt.str_en = en_update(st_r.str_en, en_field(reg_wdata, STRING_EN_POS));
			st_nxt.led_en = en_update(st_r.led_en, en_field(reg_wdata, LED_EN_POS));
		end
		if (reg_rd) begin
			case (reg_addr)
				LED_FAULT_IRQ_ENABLES_OFS: begin
					st_nxt.rdata = en_image;
				end
				SUPPLY_FAULT_FLAGS_OFS: begin
					st_nxt.rdata = status_image;
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
		st_nxt.irq = pending && st_r.glb_en;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= '0;
			st_r.rsvd   <= RSVD_RST;
			st_r.glb_en <= EN_RST;
			st_r.i2c_en <= EN_RST;
			st_r.str_en <= EN_RST;
			st_r.led_en <= EN_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata  = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign fault_irq  = st_r.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_read_enables;
		reg_rd && (reg_addr == LED_FAULT_IRQ_ENABLES_OFS) && !wr_en_reg;
	endsequence

	sequence s_crc_pair_write;
		wr_status && reg_wdata[15] && reg_wdata[14] && !supply_fault_event[CRC_FAULT_IDX];
	endsequence

	a_en_read_code: assert property (
		s_read_enables ##1 reg_rvalid |-> reg_rdata[GLOBAL_EN_POS +: 2]
			== (st_r.glb_en ? 2'h2 : 2'h0))
		else $error("enable read code wrong");

	a_en_write_on: assert property (
		(wr_en_reg && reg_wdata[7:6] == 2'h3) |=> st_r.glb_en ##1 fault_irq == $past(pending))
		else $error("enable write 3h did not enable");

	a_en_write_off: assert property (
		(wr_en_reg && reg_wdata[5:4] == 2'h1) |=> !st_r.i2c_en)
		else $error("enable write 1h did not disable");

	a_en_no_qual: assert property (
		(wr_en_reg && !reg_wdata[2]) |=> $stable(st_r.str_en))
		else $error("unqualified write changed enable");

	a_rsvd_readback: assert property (
		s_read_enables |=> reg_rdata[15:8] == $past(st_r.rsvd))
		else $error("reserved byte readback wrong");

	a_status_image: assert property (
		(reg_rd && reg_addr == SUPPLY_FAULT_FLAGS_OFS) |=>
			reg_rdata[15] == $past(flags[CRC_FAULT_IDX]) && reg_rdata[14] == 1'b0)
		else $error("status readback wrong");

	a_crc_pair_clear: assert property (
		s_crc_pair_write |=> !flags[CRC_FAULT_IDX])
		else $error("crc pair write did not clear");

	a_single_bit_hold: assert property (
		(wr_status && reg_wdata[1:0] == 2'h2 && flags[INPUT_UNDERVOLT_IDX])
			|=> flags[INPUT_UNDERVOLT_IDX])
		else $error("single status bit cleared flag");

	a_irq_follows: assert property (
		(pending && st_r.glb_en) |=> fault_irq)
		else $error("irq not raised for enabled fault");

	a_irq_gated: assert property (
		!st_r.glb_en |=> !fault_irq)
		else $error("irq raised with global enable off");

	a_unmapped_zero: assert property (
		(reg_rd && reg_addr != LED_FAULT_IRQ_ENABLES_OFS
			&& reg_addr != SUPPLY_FAULT_FLAGS_OFS) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	a_reset_values: assert property (
		$rose(rst_n) |-> (en_image == LED_FAULT_IRQ_ENABLES_RST)
			&& (status_image == SUPPLY_FAULT_FLAGS_RST) && !fault_irq && !reg_rvalid)
		else $error("state after reset wrong");

	a_event_sets: assert property (
		(|supply_fault_event) |=>
			(flags & $past(supply_fault_event)) == $past(supply_fault_event))
		else $error("fault event not latched");

	a_pair_clears: assert property (
		(|(pair_ack & ~supply_fault_event)) |=>
			(flags & $past(pair_ack & ~supply_fault_event)) == '0)
		else $error("paired write did not clear flag");

	a_ack_reads_zero: assert property (
		(reg_rd && reg_addr == SUPPLY_FAULT_FLAGS_OFS) |=> (reg_rdata & 16'h5555) == 16'h0000)
		else $error("ack bits read back nonzero");

	a_led_en_write: assert property (
		(wr_en_reg && reg_wdata[1:0] == EN_WR_OFF) |=> !st_r.led_en)
		else $error("led fault enable not disabled");

	a_str_en_write: assert property (
		(wr_en_reg && reg_wdata[3:2] == EN_WR_ON) |=> st_r.str_en)
		else $error("string enable not enabled");

	a_rsvd_store: assert property (
		wr_en_reg |=> st_r.rsvd == $past(reg_wdata[15:8]))
		else $error("reserved byte not stored");

	a_pump_pair_map: assert property (
		(wr_status && reg_wdata[11:10] == 2'h3 && !supply_fault_event[PUMP_FAULT_IDX])
			|=> !flags[PUMP_FAULT_IDX])
		else $error("pump fault pair not at its bits");

	a_sync_pair_map: assert property (
		(wr_status && reg_wdata[13:12] == 2'h3 && !supply_fault_event[SYNC_LOSS_IDX])
			|=> !flags[SYNC_LOSS_IDX])
		else $error("sync loss pair not at its bits");

	a_rvalid_answer: assert property (
		reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");

	a_rvalid_single: assert property (
		!reg_rd |=> !reg_rvalid)
		else $error("read valid without a read");

	// host may sample read data late, so it must not move between reads
	a_rdata_holds: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	// event, then flag with enables on, then the registered interrupt
	sequence s_crc_raise;
		supply_fault_event[CRC_FAULT_IDX] ##1 (supply_fault_en[CRC_FAULT_IDX] && st_r.glb_en);
	endsequence

	a_crc_irq_path: assert property (
		s_crc_raise |=> fault_irq)
		else $error("crc fault did not raise irq");

endmodule

// *** pkg/fault_irq_pkg.sv ***
// constants for the fault interrupt enable and supply fault status block
package fault_irq_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 16;
	localparam int NUM_FAULTS = 8;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] LED_FAULT_IRQ_ENABLES_OFS = 8'h0c;
	localparam logic [7:0] SUPPLY_FAULT_FLAGS_OFS    = 8'h0e;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0] LED_FAULT_IRQ_ENABLES_RST = 16'h00aa;
	localparam logic [15:0] SUPPLY_FAULT_FLAGS_RST    = 16'h0000;
	localparam logic [7:0]  RSVD_RST                  = 8'h00;
	localparam logic        EN_RST                    = 1'b1;

	// ****************************************************************
	// two-bit enable codes
	// ****************************************************************
	localparam logic [1:0] EN_RD_OFF = 2'h0;
	localparam logic [1:0] EN_RD_ON  = 2'h2;
	localparam logic [1:0] EN_WR_OFF = 2'h1;
	localparam logic [1:0] EN_WR_ON  = 2'h3;

	// ****************************************************************
	// enable field positions (low bit of each pair) and reserved byte position
	// ****************************************************************
	localparam int GLOBAL_EN_POS = 6;
	localparam int I2C_EN_POS    = 4;
	localparam int STRING_EN_POS = 2;
	localparam int LED_EN_POS    = 0;
	localparam int RSVD_POS      = 8;

	// ****************************************************************
	// fault indices; status bit is 2*idx+1, ack bit is 2*idx
	// ****************************************************************
	localparam int CRC_FAULT_IDX        = 7;
	localparam int SYNC_LOSS_IDX        = 6;
	localparam int PUMP_FAULT_IDX       = 5;
	localparam int PUMP_CAP_MISSING_IDX = 4;
	localparam int INPUT_OVERCURR_IDX   = 3;
	localparam int CORE_UNDERVOLT_IDX   = 2;
	localparam int INPUT_OVERVOLT_IDX   = 1;
	localparam int INPUT_UNDERVOLT_IDX  = 0;

endpackage

// *** verilog/fault_pair_cell.sv ***
// one latched fault flag with its paired write-one acknowledge
`timescale 1ns/1ns

module fault_pair_cell
	import fault_irq_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic fault_event,
	input  wire logic pair_ack,
	output logic      flag
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic flag;
	} cell_state_t;

	cell_state_t st_r;
	cell_state_t st_nxt;

	// event beats ack in the same cycle so no fault is lost
	always_comb begin
		st_nxt = st_r;
		if (fault_event) begin
			st_nxt.flag = 1'b1;
		end else if (pair_ack) begin
			st_nxt.flag = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_set_wins_ack: assert property (@(posedge clock) disable iff (!rst_n)
		fault_event |=> flag)
		else $error("fault event lost");

	a_ack_clears_flag: assert property (@(posedge clock) disable iff (!rst_n)
		(pair_ack && !fault_event) |=> !flag)
		else $error("paired ack did not clear flag");

	a_flag_holds: assert property (@(posedge clock) disable iff (!rst_n)
		(flag && !pair_ack) |=> flag)
		else $error("flag dropped without paired ack");

endmodule

// *** bench/host_model.sv ***
// host side model issuing register reads and writes to the fault block
`timescale 1ns/1ns

module host_model
	import fault_irq_pkg::*;
(
	input  wire logic              clock,
	output logic [ADDR_W-1:0]      reg_addr,
	output logic                   reg_wr,
	output logic                   reg_rd,
	output logic [DATA_W-1:0]      reg_wdata,
	input  wire logic [DATA_W-1:0] reg_rdata,
	input  wire logic              reg_rvalid
);
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
	end

	// one-cycle write strobe; data inverted afterwards so stale data never looks valid
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// bounded wait for the answer; a missing answer hands back unknowns
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (reg_rvalid !== 1'b1 && n < 4);
		d = (n < 4) ? reg_rdata : 'x;
	endtask
endmodule

// *** bench/fault_irq_ctrl_bench.sv ***
// self-checking bench for the fault enable and supply status block
`timescale 1ns/1ns

module fault_irq_ctrl_bench
	import fault_irq_pkg::*;
;
	localparam logic [7:0] EA = LED_FAULT_IRQ_ENABLES_OFS;
	localparam logic [7:0] SA = SUPPLY_FAULT_FLAGS_OFS;

	logic                  clock;
	logic                  rst_n;
	logic [ADDR_W-1:0]     reg_addr;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [DATA_W-1:0]     reg_wdata;
	logic [NUM_FAULTS-1:0] ev;
	logic [NUM_FAULTS-1:0] fen;
	logic [2:0]            pend;
	logic [DATA_W-1:0]     reg_rdata;
	logic                  reg_rvalid;
	logic                  fault_irq;
	logic [NUM_FAULTS-1:0] fault_flags;
	int                    fails;
	int                    n_checks;
	int                    cyc;

	fault_irq_ctrl i_fault_irq_ctrl (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .supply_fault_event(ev),
		.supply_fault_en(fen), .i2c_timeout_pending(pend[2]), .bad_string_pending(pend[1]),
		.led_fault_pending(pend[0]), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.fault_irq(fault_irq), .fault_flags(fault_flags));

	host_model i_host_model (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ceiling well above the few hundred cycles the sequence needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			stop_test;
		end
	end

	task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		i_host_model.rd(a, v);
		chk($sformatf("register %h", a), v, e);
	endtask

	task automatic settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	initial begin
		cyc = 0;
		fails = 0;
		n_checks = 0;
		ev = '0;
		fen = '1;
		pend = '0;
		rst_n = 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rchk(EA, 16'h00aa);
		rchk(SA, 16'h0000);
		chk("reg_rvalid", {15'h0, reg_rvalid}, 16'h0001);
		@(negedge clock);
		chk("reg_rvalid", {15'h0, reg_rvalid}, 16'h0000);
		chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
		$display("test reset done");
		for (int p = 0; p < 8; p += 2) begin
			i_host_model.wr(EA, 16'h0001 << p);
			rchk(EA, 16'h00aa & ~(16'h0003 << p));
			i_host_model.wr(EA, 16'h0002 << p);
			i_host_model.wr(EA, 16'h0000);
			rchk(EA, 16'h00aa & ~(16'h0003 << p));
			i_host_model.wr(EA, 16'h0003 << p);
			rchk(EA, 16'h00aa);
			i_host_model.wr(EA, 16'h0002 << p);
			rchk(EA, 16'h00aa);
		end
		$display("test enables done");
		i_host_model.wr(EA, 16'h5a00);
		rchk(EA, 16'h5aaa);
		i_host_model.wr(8'h10, 16'hffff);
		rchk(8'h10, 16'h0000);
		rchk(SA, 16'h0000);
		i_host_model.wr(EA, 16'h0000);
		rchk(EA, 16'h00aa);
		$display("test reserved and unmapped done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			ev <= 8'h01 << i;
			@(posedge clock);
			ev <= '0;
			settle;
			chk("fault_flags", {8'h0, fault_flags}, {8'h0, 8'h01 << i});
			chk("fault_irq", {15'h0, fault_irq}, 16'h0001);
			rchk(SA, 16'h0002 << (2 * i));
			i_host_model.wr(SA, 16'h0002 << (2 * i));
			i_host_model.wr(SA, 16'h0001 << (2 * i));
			rchk(SA, 16'h0002 << (2 * i));
			i_host_model.wr(SA, 16'h0003 << (2 * i));
			settle;
			rchk(SA, 16'h0000);
			chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
		end
		$display("test faults done");
		// event held across the clearing write: the event must win
		@(posedge clock);
		ev <= 8'h01;
		i_host_model.wr(SA, 16'h0003);
		ev <= '0;
		settle;
		chk("fault_flags", {8'h0, fault_flags}, 16'h0001);
		i_host_model.wr(SA, 16'h0003);
		rchk(SA, 16'h0000);
		$display("test set beats clear done");
		@(posedge clock);
		fen <= 8'h7f;
		ev <= 8'h80;
		@(posedge clock);
		ev <= '0;
		settle;
		chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
		@(posedge clock);
		fen <= 8'hff;
		settle;
		chk("fault_irq", {15'h0, fault_irq}, 16'h0001);
		i_host_model.wr(EA, 16'h0040);
		settle;
		chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
		i_host_model.wr(EA, 16'h00c0);
		settle;
		chk("fault_irq", {15'h0, fault_irq}, 16'h0001);
		i_host_model.wr(SA, 16'hc000);
		for (int j = 0; j < 3; j++) begin
			@(posedge clock);
			pend <= 3'h1 << j;
			settle;
			chk("fault_irq", {15'h0, fault_irq}, 16'h0001);
			i_host_model.wr(EA, 16'h0001 << (2 * j));
			settle;
			chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
			i_host_model.wr(EA, 16'h0003 << (2 * j));
			pend <= '0;
		end
		$display("test masking done");
		i_host_model.wr(EA, 16'h5a55);
		@(posedge clock);
		ev <= 8'hff;
		@(posedge clock);
		ev <= '0;
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rchk(EA, 16'h00aa);
		rchk(SA, 16'h0000);
		chk("fault_flags", {8'h0, fault_flags}, 16'h0000);
		chk("fault_irq", {15'h0, fault_irq}, 16'h0000);
		$display("test reset again done");
		stop_test;
	end
endmodule
